/* File: logic/aca_annunciator.sv */
// Alarm change-of-state annunciator with acknowledge and APB registers
`timescale 1ns/1ps

// Overview of operation
// - New alarm energises relay and its indicator
// - Acknowledge marks active alarms, releases relay
// - Alarm after acknowledge release re-energises relay
// - No unacknowledged alarm left de-energises relay
// - Recurring acknowledged alarm becomes unacknowledged again
// - Rear grounded acknowledge acts like front button
// - Indicator mirrors the relay drive exactly
// - Acknowledge also pulses audible alarm cutoff
// - Lamp test lights every status indicator
// - Status indicator lit while point alarm present
// - Low strap shows outputs 1-8 on 25-32
// - High strap shows outputs 9-16 on 57-64
// - Alive indicator only after init, while healthy
// - Up to seven expander units add points
// - Strapped outputs feed the status points
module aca_annunciator
   import aca_pkg::*;
#(
   parameter logic [DEB_CNT_W-1:0]   DEB_CYCLES   = DEB_CNT_W'(DEB_CYC),
   parameter logic [ALIVE_CNT_W-1:0] ALIVE_CYCLES = ALIVE_CNT_W'(ALIVE_CYC)
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   output logic                      irq,
   input  wire logic [NPTS-1:0]      point_alarm_in,
   input  wire logic [NEXP*NPTS-1:0] expander_parallel_bus_points,
   input  wire logic [NEXP-1:0]      expander_parallel_bus_present,
   input  wire logic                 state_change_ack_button_n,
   input  wire logic                 rear_terminal_block_ack_n,
   input  wire logic                 lamp_test_button_n,
   input  wire logic                 low_output_loopback_strap,
   input  wire logic                 high_output_loopback_strap,
   output logic                      state_change_alarm,
   output logic                      state_change_led,
   output logic                      audible_alarm_cutoff,
   output logic [NPTS-1:0]           status_led,
   output logic [NOUT-1:0]           control_out,
   output logic                      processor_alive_indicator
);

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning

   aca_debounce_if ack_if ();
   aca_debounce_if ext_if ();
   aca_debounce_if lt_if ();

   // Contacts pull to ground when closed, so invert to active high
   assign ack_if.raw = ~state_change_ack_button_n;
   assign ext_if.raw = ~rear_terminal_block_ack_n;
   assign lt_if.raw  = ~lamp_test_button_n;

   aca_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_ack_deb (
      .pclk    (pclk),
      .presetn (presetn),
      .ifc     (ack_if)
   );
   aca_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_ext_deb (
      .pclk    (pclk),
      .presetn (presetn),
      .ifc     (ext_if)
   );
   aca_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_lt_deb (
      .pclk    (pclk),
      .presetn (presetn),
      .ifc     (lt_if)
   );

   logic [NPTS-1:0]      pt_s1;
   logic [NPTS-1:0]      pt_s2;
   logic [NEXP*NPTS-1:0] ex_s1;
   logic [NEXP*NPTS-1:0] ex_s2;
   logic [NEXP-1:0]      pres_s1;
   logic [NEXP-1:0]      pres_s2;
   logic [1:0]           strap_s1;
   logic [1:0]           strap_s2;

   // Pin-level point and strap inputs pass two flops first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pt_s1    <= '0;
         pt_s2    <= '0;
         ex_s1    <= '0;
         ex_s2    <= '0;
         pres_s1  <= '0;
         pres_s2  <= '0;
         strap_s1 <= '0;
         strap_s2 <= '0;
      end else begin
         pt_s1    <= point_alarm_in;
         pt_s2    <= pt_s1;
         ex_s1    <= expander_parallel_bus_points;
         ex_s2    <= ex_s1;
         pres_s1  <= expander_parallel_bus_present;
         pres_s2  <= pres_s1;
         strap_s1 <= {high_output_loopback_strap, low_output_loopback_strap};
         strap_s2 <= strap_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Point states and acknowledge tracking

   logic [NPTS-1:0]  base_pts;
   logic [NALL-1:0]  active;
   logic [NALL-1:0]  active_d;
   logic [NALL-1:0]  acked;
   logic [NALL-1:0]  unack;
   logic             sw_ack;
   logic             ack_evt;
   logic             new_alarm;

   // Strapped control outputs replace the top eight points of a bank
   always_comb begin
      base_pts = pt_s2;
      if (strap_s2[0]) begin
         base_pts[LOW_LOOP_POS +: LOOP_W] =
            control_out[0 +: LOOP_W];
      end
      if (strap_s2[1]) begin
         base_pts[HIGH_LOOP_POS +: LOOP_W] =
            control_out[HIGH_OUT_POS +: LOOP_W];
      end
   end

   // Absent expanders contribute no alarms
   always_comb begin
      active[NPTS-1:0] = base_pts;
      for (int u = 0; u < NEXP; u++) begin
         active[(u + 1) * NPTS +: NPTS] =
            pres_s2[u] ? ex_s2[u * NPTS +: NPTS] : '0;
      end
   end

   assign ack_evt   = ack_if.press | ext_if.press | sw_ack;
   assign unack     = active & ~acked;
   assign new_alarm = |(active & ~active_d);

   // Flag set by acknowledge while active, dropped when point returns
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acked    <= '0;
         active_d <= '0;
      end else begin
         acked    <= (acked | (ack_evt ? active : '0)) & active;
         active_d <= active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Relay, indicators and audible cutoff

   // Relay and lamp share one term so they can never disagree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_change_alarm <= 1'b0;
         state_change_led   <= 1'b0;
      end else if (ack_evt) begin
         state_change_alarm <= 1'b0;
         state_change_led   <= 1'b0;
      end else begin
         state_change_alarm <= |unack;
         state_change_led   <= |unack;
      end
   end

   // One-cycle cutoff pulse for the office audible alarm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         audible_alarm_cutoff <= 1'b0;
      end else begin
         audible_alarm_cutoff <= ack_evt;
      end
   end

   // Lamp test overrides every point indication
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_led <= '0;
      end else if (lt_if.level) begin
         status_led <= '1;
      end else begin
         status_led <= base_pts;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Processor-alive supervision

   aca_alive_t                 alive_st;
   logic [ALIVE_CNT_W-1:0]     alive_cnt;
   logic                       init_done;
   logic                       kick;
   logic                       alive_lost;

   // Software must keep kicking, else the indicator drops until init_done is cleared and set again
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alive_st  <= ACA_BOOT;
         alive_cnt <= '0;
      end else begin
         case (alive_st)
            ACA_BOOT: begin
               alive_cnt <= ALIVE_CYCLES;
               if (init_done) begin
                  alive_st <= ACA_RUN;
               end
            end
            ACA_RUN: begin
               if (!init_done || alive_cnt == '0) begin
                  alive_st <= ACA_FAIL;
               end else if (kick) begin
                  alive_cnt <= ALIVE_CYCLES;
               end else begin
                  alive_cnt <= alive_cnt - 1'b1;
               end
            end
            ACA_FAIL: begin
               if (!init_done) begin
                  alive_st <= ACA_BOOT;
               end
            end
            default: alive_st <= ACA_BOOT;
         endcase
      end
   end

   assign alive_lost = (alive_st == ACA_RUN) &&
                       (!init_done || alive_cnt == '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processor_alive_indicator <= 1'b0;
      end else begin
         processor_alive_indicator <= (alive_st == ACA_RUN) &&
                                      !alive_lost;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave

   logic                  setup;
   logic                  wr_acc;
   logic                  mapped;
   logic [IRQ_W-1:0]      irq_stat;
   logic [IRQ_W-1:0]      irq_mask;
   logic [IRQ_W-1:0]      irq_evt;
   logic [UNIT_SEL_W-1:0] unit_sel;
   logic [NPTS-1:0]       sel_act;
   logic [NPTS-1:0]       sel_unack;
   logic [31:0]           next_rdata;

   assign setup  = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign mapped = (paddr <= REG_KICK) && (paddr[1:0] == 2'b00);
   assign kick   = wr_acc && (paddr == REG_KICK);
   assign sw_ack = wr_acc && (paddr == REG_CTRL) && pwdata[CTRL_SW_ACK];

   // Zero-wait slave: data is prepared in setup, valid in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= RESET_WORD;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= !mapped;
            prdata  <= pwrite ? RESET_WORD : next_rdata;
         end
      end
   end

   // Software-owned control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_done   <= 1'b0;
         irq_mask    <= '0;
         control_out <= '0;
         unit_sel    <= '0;
      end else if (wr_acc) begin
         case (paddr)
            REG_CTRL:     init_done   <= pwdata[CTRL_INIT_DONE];
            REG_IRQ_MASK: irq_mask    <= pwdata[IRQ_W-1:0];
            REG_CTL_OUT:  control_out <= pwdata[NOUT-1:0];
            REG_UNIT_SEL: unit_sel    <= pwdata[UNIT_SEL_W-1:0];
            default:      unit_sel    <= unit_sel;
         endcase
      end
   end

   assign irq_evt = {alive_lost, ack_evt, new_alarm};

   // Sticky events; a new event beats a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
      end else if (wr_acc && paddr == REG_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat <= irq_stat | irq_evt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat & irq_mask);
      end
   end

   assign sel_act   = active[{unit_sel, 6'h00} +: NPTS];
   assign sel_unack = unack[{unit_sel, 6'h00} +: NPTS];

   // Read mux; the point and unacknowledged words show the unit chosen by the select register
   always_comb begin
      next_rdata = RESET_WORD;
      case (paddr)
         REG_CTRL:     next_rdata[CTRL_INIT_DONE] = init_done;
         REG_IRQ_STAT: next_rdata[IRQ_W-1:0]      = irq_stat;
         REG_IRQ_MASK: next_rdata[IRQ_W-1:0]      = irq_mask;
         REG_CTL_OUT:  next_rdata[NOUT-1:0]       = control_out;
         REG_PT_LO:    next_rdata                 = sel_act[31:0];
         REG_PT_HI:    next_rdata                 = sel_act[63:32];
         REG_UNACK_LO: next_rdata                 = sel_unack[31:0];
         REG_UNACK_HI: next_rdata                 = sel_unack[63:32];
         REG_UNIT_SEL: next_rdata[UNIT_SEL_W-1:0] = unit_sel;
         default:      next_rdata                 = RESET_WORD;
      endcase
   end

endmodule // aca_annunciator

/* File: logic/aca_debounce.sv */
// Synchroniser, debouncer and press detector for one contact input
`timescale 1ns/1ps
module aca_debounce
   import aca_pkg::*;
#(
   parameter logic [DEB_CNT_W-1:0] DEB_CYCLES = DEB_CNT_W'(DEB_CYC)
) (
   input wire logic        pclk,
   input wire logic        presetn,
   aca_debounce_if.filt    ifc
);

   logic                 sync1;
   logic                 sync2;
   logic [DEB_CNT_W-1:0] cnt;

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= ifc.raw;
         sync2 <= sync1;
      end
   end

   // Level accepted only after it stays steady for the debounce time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= '0;
         ifc.level <= 1'b0;
      end else if (sync2 == ifc.level) begin
         cnt <= '0;
      end else if (cnt >= DEB_CYCLES - 1'b1) begin
         cnt       <= '0;
         ifc.level <= sync2;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // One pulse on the asserting edge, so a held press acts once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ifc.press <= 1'b0;
      end else begin
         ifc.press <= (sync2 != ifc.level) && sync2 &&
                      (cnt >= DEB_CYCLES - 1'b1);
      end
   end

endmodule // aca_debounce

/* File: logic/aca_debounce_if.sv */
// Carrier between the annunciator and its input conditioners
`timescale 1ns/1ps
interface aca_debounce_if;
   logic raw;
   logic level;
   logic press;
   modport filt (input raw, output level, output press);
   modport user (output raw, input level, input press);
endinterface

/* File: logic/aca_pkg.sv */
// Shared constants for the alarm change-of-state annunciator
package aca_pkg;

   // Clock and timing
   localparam int CLK_HZ           = 250_000_000;
   localparam int DEBOUNCE_MS      = 10;
   localparam int DEB_CYC          = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int DEB_CNT_W        = 22;
   localparam int ALIVE_TIMEOUT_MS = 1000;
   localparam int ALIVE_CYC        = ALIVE_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int ALIVE_CNT_W      = 28;

   // Point geometry: unit 0 is the base, units 1..7 are expanders
   localparam int NPTS   = 64;
   localparam int NEXP   = 7;
   localparam int NUNITS = NEXP + 1;
   localparam int NALL   = NUNITS * NPTS;
   localparam int NOUT   = 16;
   localparam int LOOP_W = 8;
   localparam int LOW_LOOP_POS  = 24;
   localparam int HIGH_LOOP_POS = 56;
   localparam int HIGH_OUT_POS  = 8;

   // APB register byte offsets
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_CTL_OUT  = 8'h0C;
   localparam logic [7:0] REG_PT_LO    = 8'h10;
   localparam logic [7:0] REG_PT_HI    = 8'h14;
   localparam logic [7:0] REG_UNACK_LO = 8'h18;
   localparam logic [7:0] REG_UNACK_HI = 8'h1C;
   localparam logic [7:0] REG_UNIT_SEL = 8'h20;
   localparam logic [7:0] REG_KICK     = 8'h24;

   // CTRL fields
   localparam int CTRL_INIT_DONE = 0;
   localparam int CTRL_SW_ACK    = 1;

   // Interrupt status fields
   localparam int IRQ_W         = 3;
   localparam int IRQ_NEW_ALARM = 0;
   localparam int IRQ_ACK       = 1;
   localparam int IRQ_ALIVE_OFF = 2;

   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam int UNIT_SEL_W = 3;

   // Processor-alive supervision states
   typedef enum logic [1:0] {ACA_BOOT, ACA_RUN, ACA_FAIL} aca_alive_t;

endpackage

/* File: sim/aca_annunciator_asserts.sv */
// Pin-level checks for the alarm change-of-state annunciator
`timescale 1ns/1ps
module aca_annunciator_asserts
   import aca_pkg::*;
#(
   parameter logic [DEB_CNT_W-1:0] DEB_CYCLES = DEB_CNT_W'(DEB_CYC)
) (
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic [NPTS-1:0] point_alarm_in,
   input wire logic [NEXP-1:0] expander_parallel_bus_present,
   input wire logic            state_change_ack_button_n,
   input wire logic            rear_terminal_block_ack_n,
   input wire logic            lamp_test_button_n,
   input wire logic            low_output_loopback_strap,
   input wire logic            high_output_loopback_strap,
   input wire logic            state_change_alarm,
   input wire logic            state_change_led,
   input wire logic            audible_alarm_cutoff,
   input wire logic [NPTS-1:0] status_led,
   input wire logic [NOUT-1:0] control_out
);
   logic [DEB_CNT_W:0] lamp_run;
   logic               lamp_prev, lamp_ok, lo, hi;
   logic [3:0]         calm;
   ////////////////////////////////////////////////////////////
   // Lamp pin hold time; the filter makes indicators lag by its length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lamp_run  <= '0;
         lamp_prev <= 1'b1;
      end else begin
         lamp_prev <= lamp_test_button_n;
         if (lamp_test_button_n != lamp_prev) lamp_run <= '0;
         else if (lamp_run != '1) lamp_run <= lamp_run + 1'b1;
      end
   end
   // Quiet time on both acknowledge contacts, so no press is in flight
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) calm <= '0;
      else if (!state_change_ack_button_n || !rear_terminal_block_ack_n)
         calm <= '0;
      else if (calm != 4'hF) calm <= calm + 4'h1;
   end
   assign lamp_ok = lamp_test_button_n && lamp_run > DEB_CYCLES + 8;
   assign lo      = low_output_loopback_strap;
   assign hi      = high_output_loopback_strap;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_led_mirror: assert property (
      state_change_led == state_change_alarm)
      else $error("indicator differs from relay drive");
   chk_relay_rise: assert property (calm == 4'hF && !lo && !hi &&
      (point_alarm_in & ~$past(point_alarm_in)) != '0
      |-> ##[1:4] state_change_alarm) else $error("new alarm left relay off");
   chk_relay_idle: assert property (
      (point_alarm_in == '0 && !lo && !hi &&
      expander_parallel_bus_present == '0)[*5] |=> !state_change_alarm)
      else $error("relay held with no alarm active");
   chk_cutoff_pulse: assert property (audible_alarm_cutoff |=>
      !audible_alarm_cutoff) else $error("cutoff longer than one cycle");
   chk_ack_release: assert property (audible_alarm_cutoff |->
      !state_change_alarm) else $error("relay kept on acknowledge");
   chk_lamp_all: assert property (!lamp_test_button_n &&
      lamp_run == DEB_CYCLES + 8 |-> &status_led)
      else $error("lamp test dark");
   chk_point_led: assert property ((lamp_ok && !lo && !hi &&
      $stable(point_alarm_in))[*5] |-> status_led == point_alarm_in)
      else $error("status indicators differ from points");
   chk_low_loop: assert property ((lamp_ok && lo && !hi &&
      $stable(control_out))[*5] |-> status_led[31:24] == control_out[7:0])
      else $error("low loopback indicators wrong");
   chk_high_loop: assert property ((lamp_ok && hi && !lo &&
      $stable(control_out))[*5] |-> status_led[63:56] == control_out[15:8])
      else $error("high loopback indicators wrong");
   cov_relay: cover property ($rose(state_change_alarm));
   cov_cutoff: cover property (audible_alarm_cutoff);
   cov_lamp: cover property (!lamp_test_button_n && &status_led);
endmodule // aca_annunciator_asserts

bind aca_annunciator aca_annunciator_asserts #(.DEB_CYCLES(DEB_CYCLES))
   i_aca_annunciator_asserts (.pclk, .presetn, .point_alarm_in,
   .expander_parallel_bus_present, .state_change_ack_button_n,
   .rear_terminal_block_ack_n, .lamp_test_button_n, .status_led,
   .low_output_loopback_strap, .high_output_loopback_strap, .control_out,
   .state_change_alarm, .state_change_led, .audible_alarm_cutoff);

/* File: sim/aca_annunciator_test.sv */
// Self-checking bench for the alarm change-of-state annunciator
`timescale 1ns/1ps
module aca_annunciator_test import aca_pkg::*; ;
   logic                 pclk, presetn, psel, penable, pwrite, pready;
   logic                 pslverr, irq, lo_s, hi_s, scr, led, cut, alive;
   logic                 f_req, r_req, l_req, f_n, r_n, l_n, e;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata, q, d;
   logic [NPTS-1:0]      pts, sled;
   logic [NEXP*NPTS-1:0] xpts;
   logic [NEXP-1:0]      xpres;
   logic [NOUT-1:0]      ctl;
   int                   n_errors, tests_run, n_cut, k, u;
   ////////////////////////////////////////////////////////////
   // Short filter and watchdog keep the run brief
   aca_annunciator #(.DEB_CYCLES(22'd4), .ALIVE_CYCLES(28'd50))
      i_aca_annunciator (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
      .point_alarm_in(pts), .expander_parallel_bus_points(xpts),
      .expander_parallel_bus_present(xpres), .state_change_ack_button_n(f_n),
      .rear_terminal_block_ack_n(r_n), .lamp_test_button_n(l_n),
      .low_output_loopback_strap(lo_s), .high_output_loopback_strap(hi_s),
      .state_change_alarm(scr), .state_change_led(led),
      .audible_alarm_cutoff(cut), .status_led(sled), .control_out(ctl),
      .processor_alive_indicator(alive));
   aca_panel i_aca_panel (.pclk, .front_req(f_req), .rear_req(r_req),
      .lamp_req(l_req), .front_n(f_n), .rear_n(r_n), .lamp_n(l_n));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Cutoff is a one-cycle pulse, so count it on every edge
   always @(posedge pclk) if (cut === 1'b1) n_cut++;
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask
   // One transfer; only the watchdog bounds the wait for pready
   task automatic apb(input logic w, input logic [7:0] a, input int v);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 32'(v)};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic setp(input logic [63:0] v);
      @(posedge pclk);
      pts <= v;
      tick(8);
   endtask
   // Long hold of one acknowledge contact; it must act once
   task automatic press(input bit rear);
      int c0;
      c0 = n_cut;
      @(posedge pclk);
      {r_req, f_req} <= {rear, !rear};
      tick(20);
      chk(64'(n_cut - c0), 1);
      {r_req, f_req} <= 2'b00;
      tick(14);
   endtask
   function automatic logic [63:0] exp_led(input logic [63:0] p,
      input logic [15:0] c, input logic lo, input logic hi, input logic lt);
      logic [63:0] r;
      r = p;
      if (lo) r[31:24] = c[7:0];
      if (hi) r[63:56] = c[15:8];
      return lt ? '1 : r;
   endfunction
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, lo_s, hi_s, f_req, r_req, l_req} = '0;
      {paddr, pwdata, pts, xpts, xpres} = '0;
      {n_errors, tests_run, n_cut} = '0;
      presetn = 1'b0;
      void'($urandom(51781));
      tick(10);
      presetn <= 1'b1;
      tick(2);
      chk({scr, led, cut, alive, irq}, 0);
      // Every mapped word reads zero; stray addresses are refused
      for (k = 0; k < 10; k++) begin
         apb(0, 8'(k * 4), 0);
         chk({e, q}, 0);
      end
      apb(0, 8'h28, 0);
      chk(e, 1);
      apb(1, 8'h02, 15);
      chk(e, 1);
      done("reset");
      apb(1, REG_IRQ_MASK, 7);
      k = $urandom_range(23, 0);
      setp(64'h1 << k);
      chk({scr, led, irq}, 3'b111);
      chk(sled, exp_led(pts, 0, 0, 0, 0));
      apb(0, REG_UNACK_LO, 0);
      chk(q, 32'h1 << k);
      // Masking hides the event; write one clears it
      for (u = 0; u < 3; u++) begin
         apb(1, u == 2 ? REG_IRQ_STAT : REG_IRQ_MASK, u == 0 ? 0 : 7);
         tick(2);
         chk(irq, u == 1);
      end
      done("alarm");
      press(0);
      chk({scr, led}, 0);
      apb(0, REG_UNACK_LO, 0);
      chk(q, 0);
      apb(0, REG_IRQ_STAT, 0);
      chk(q[1], 1);
      setp(pts | (64'h1 << (k + 32)));
      chk({scr, led}, 2'b11);
      press(1);
      chk(scr, 0);
      setp(pts & ~(64'h1 << k));
      setp(pts | (64'h1 << k));
      chk(scr, 1);
      setp(pts & ~(64'h1 << k));
      chk(scr, 0);
      done("ack");
      setp({$urandom, $urandom} & 64'h00FF_FFFF_00FF_FFFF);
      // Software acknowledge must act like a button press
      k = n_cut;
      apb(1, REG_CTRL, 1 << CTRL_SW_ACK);
      tick(2);
      chk({scr, led}, 0);
      chk(64'(n_cut - k), 1);
      @(posedge pclk);
      l_req <= 1'b1;
      tick(14);
      chk(sled, exp_led(pts, 0, 0, 0, 1));
      l_req <= 1'b0;
      tick(14);
      chk(sled, exp_led(pts, 0, 0, 0, 0));
      done("lamp");
      d = $urandom;
      apb(1, REG_CTL_OUT, d);
      tick(1);
      chk(ctl, d[15:0]);
      for (u = 0; u < 4; u++) begin
         @(posedge pclk);
         {hi_s, lo_s} <= u[1:0];
         tick(8);
         chk(sled, exp_led(pts, d[15:0], u[0], u[1], 0));
      end
      done("loopback");
      for (u = 0; u < 14; u++) xpts[u*32+:32] <= $urandom;
      xpres <= 7'($urandom);
      tick(6);
      for (u = 1; u <= NEXP; u++) begin
         apb(1, REG_UNIT_SEL, u);
         apb(0, REG_PT_LO, 0);
         d = q;
         apb(0, REG_PT_HI, 0);
         chk({q, d}, xpres[u-1] ? xpts[(u-1)*NPTS+:NPTS] : 64'h0);
      end
      done("expander");
      apb(1, REG_CTRL, 1);
      tick(3);
      chk(alive, 1);
      repeat (3) begin
         tick(25);
         apb(1, REG_KICK, 0);
      end
      chk(alive, 1);
      tick(70);
      chk(alive, 0);
      apb(0, REG_IRQ_STAT, 0);
      chk(q[2], 1);
      done("alive");
      end_sim();
   end
endmodule // aca_annunciator_test

/* File: sim/aca_panel.sv */
// Front panel buttons and rear acknowledge contact model
`timescale 1ns/1ps
module aca_panel (
   input  wire logic pclk,
   input  wire logic front_req,
   input  wire logic rear_req,
   input  wire logic lamp_req,
   output logic      front_n,
   output logic      rear_n,
   output logic      lamp_n
);
   // Released contacts float back to the pull-up, never left unknown
   initial {front_n, rear_n, lamp_n} = 3'b111;
   // Contacts close to ground while requested
   always @(posedge pclk) begin
      front_n <= ~front_req;
      rear_n  <= ~rear_req;
      lamp_n  <= ~lamp_req;
   end
endmodule // aca_panel
